// ===== rtl/rx_ctl_pkg.sv
/*
 Shared constants for the receiver state block and its controller:
 device register map, field positions, controller register map, timing.
 Assumes a single 10 MHz core clock shared by both ends.
*/
package rx_ctl_pkg;
    localparam int CLK_MHZ = 10;
    localparam int ADDR_W = 6;
    localparam int REG_NUM = 64;
    // Device register offsets
    localparam logic [5:0] A_BW = 6'h02;
    localparam logic [5:0] A_THRESHOLD_METHOD = 6'h03;
    localparam logic [5:0] A_ASK_THRESHOLD_LOWER_BOUND = 6'h04;
    localparam logic [5:0] A_AFC = 6'h08;
    localparam logic [5:0] A_LO_HI = 6'h09;
    localparam logic [5:0] A_LO_MID = 6'h0a;
    localparam logic [5:0] A_LO_LO = 6'h0b;
    localparam logic [5:0] A_BANK_LAST = 6'h0e;
    localparam logic [5:0] A_FEI = 6'h11;
    localparam logic [5:0] A_STATE_CTRL = 6'h14;
    localparam logic [5:0] A_RX_STATE = 6'h15;
    localparam logic [5:0] A_AFE = 6'h19;
    localparam logic [5:0] A_LOCK = 6'h27;
    // Field positions
    localparam int STC_OSC = 2;
    localparam int STC_WUT = 1;
    localparam int STC_RX = 0;
    localparam int LOCK_BIT = 0;
    localparam int THRESHOLD_METHOD_BIT = 7;
    localparam int BW_IF_BIT = 4;
    localparam int BW_CHF_LSB = 0;
    localparam int BW_CHF_W = 3;
    localparam int AFC_LSB = 0;
    localparam int AFC_W = 3;
    localparam int AFE_LODIV_LSB = 1;
    localparam logic [7:0] AFE_RESET = 8'h93;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [1:0] RXS_STANDBY = 2'h0;
    localparam logic [1:0] RXS_ACTIVE = 2'h1;
    localparam logic [1:0] RXS_WAIT_POLL = 2'h2;
    // Arithmetic constants
    localparam int LO_FRAC_BITS = 16;
    localparam int AFC_EXP_BASE = 10;
    localparam int ASK_AVG_SHIFT = 3;
    localparam int SETTLE_BITS = 12;
    localparam int BANK_REGS = 16;
    localparam int XTAL_KHZ = 16000;
    // Timing
    localparam int PWR_HIGH_US = 1000;
    localparam int PWR_LOW_US = 400;
    localparam int LOCK_US = 50;
    localparam int PWR_HIGH_CYC = PWR_HIGH_US * CLK_MHZ;
    localparam int PWR_LOW_CYC = PWR_LOW_US * CLK_MHZ;
    localparam int LOCK_CYC = LOCK_US * CLK_MHZ;
    // Controller registers (AXI4-Lite byte addresses)
    localparam logic [7:0] H_CMD = 8'h00;
    localparam logic [7:0] H_RESULT = 8'h04;
    localparam logic [7:0] H_IRQ_ST = 8'h08;
    localparam logic [7:0] H_IRQ_MSK = 8'h0c;
    localparam logic [7:0] H_PINS = 8'h10;
    localparam int CMD_WE_BIT = 16;
    localparam int CMD_ADDR_LSB = 8;
    localparam int RES_BUSY_BIT = 8;
    localparam int RES_READY_BIT = 9;
    localparam int EV_POWERED = 0;
    localparam int EV_DONE = 1;
    localparam int EV_REFUSED = 2;
    localparam int EV_W = 3;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [1:0] {ST_SLEEP, ST_STANDBY, ST_RECEIVE} dev_state_t;
    typedef enum logic [1:0] {H_PWR_HIGH, H_PWR_LOW, H_READY, H_ACCESS} host_state_t;
endpackage

// ===== rtl/rx_link_if.sv
/*
 Link between the controller and the receiver: power-down pin, register
 access port and the demodulated data pin.
 Assumes both ends run on core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
interface rx_link_if (
    input wire logic core_clk // Shared clock
);
    logic power_down_pin;
    logic acc_req;
    logic acc_we;
    logic [5:0] acc_addr;
    logic [7:0] acc_wdata;
    logic acc_ack;
    logic [7:0] acc_rdata;
    logic data_pin;
    modport dev (
        input power_down_pin, acc_req, acc_we, acc_addr, acc_wdata,
        output acc_ack, acc_rdata, data_pin
    );
    modport ctl (
        output power_down_pin, acc_req, acc_we, acc_addr, acc_wdata,
        input acc_ack, acc_rdata, data_pin
    );
endinterface
`default_nettype wire

// ===== rtl/rx_device.sv
/*
 Receiver device end: register file, Sleep/Standby/receive sequencing,
 synthesizer lock flag, ASK threshold and LO/AFC arithmetic.
 Assumes the controller holds acc_req until acc_ack and keeps the
 power-down pin high long enough for a clean start.
*/
`timescale 1ns/1ps
`default_nettype none
module rx_device
    import rx_ctl_pkg::*;
#(
    parameter int LOCK_CYCLES = rx_ctl_pkg::LOCK_CYC,
    parameter int XTAL_K = rx_ctl_pkg::XTAL_KHZ
) (
    input wire logic core_clk, // Clock
    input wire logic rst, // Synchronous reset, high
    rx_link_if.dev link, // Controller side
    input wire logic signed [7:0] ask_sample, // Envelope sample
    input wire logic bit_tick, // One pulse per bit period
    input wire logic signed [7:0] fei_in, // Frequency error from AFC
    output logic [23:0] lo_freq_khz, // LO centre frequency
    output logic [15:0] afc_pull_khz, // AFC correction limit
    output logic signed [7:0] ask_threshold, // Decision threshold
    output logic data_valid, // Settling over
    output logic rx_active // In active receive
);
    import rx_ctl_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Register file

    logic [7:0] cfg_q [REG_NUM];
    logic [7:0] cfg_d [REG_NUM];
    logic ack_q, ack_d;
    logic [7:0] rdata_q, rdata_d;
    logic signed [7:0] fei_q, fei_d;
    logic locked_q, locked_d;
    logic [15:0] lock_cnt_q, lock_cnt_d;
    dev_state_t st_q, st_d;

    function automatic logic read_only(input logic [5:0] a);
        return a == A_FEI || a == A_RX_STATE || a == A_LOCK;
    endfunction

    function automatic logic [7:0] reset_val(input int a);
        return (a == int'(A_AFE)) ? AFE_RESET : REG_RESET;
    endfunction

    logic [1:0] state_code;
    logic [7:0] rd_val;
    logic [7:0] ctrl;
    logic pwr_off;

    assign pwr_off = link.power_down_pin;
    assign ctrl = cfg_q[A_STATE_CTRL];

    always_comb begin
        unique case (st_q)
            ST_RECEIVE: state_code = RXS_ACTIVE;
            ST_STANDBY: state_code = ctrl[STC_WUT] ? RXS_WAIT_POLL : RXS_STANDBY;
            ST_SLEEP: state_code = RXS_STANDBY;
            default: state_code = RXS_STANDBY;
        endcase
    end

    always_comb begin
        rd_val = cfg_q[link.acc_addr];
        if (link.acc_addr == A_FEI) begin
            rd_val = fei_q;
        end else if (link.acc_addr == A_RX_STATE) begin
            rd_val = {6'h00, state_code};
        end else if (link.acc_addr == A_LOCK) begin
            rd_val = 8'h00;
            rd_val[LOCK_BIT] = locked_q;
        end
    end

    always_comb begin
        cfg_d = cfg_q;
        ack_d = 1'b0;
        rdata_d = rdata_q;
        if (pwr_off) begin
            for (int i = 0; i < REG_NUM; i++) begin
                cfg_d[i] = reset_val(i);
            end
        end else if (link.acc_req && !ack_q) begin
            ack_d = 1'b1;
            rdata_d = rd_val;
            // While powered, only an explicit write changes a register; the power-down pin resets them all
            if (link.acc_we && !read_only(link.acc_addr)) begin
                cfg_d[link.acc_addr] = link.acc_wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Operating state and synthesizer lock

    always_comb begin
        // The power-down pin and the control byte select the state
        if (pwr_off || !ctrl[STC_OSC]) begin
            st_d = ST_SLEEP;
        end else if (ctrl[STC_RX]) begin
            st_d = ST_RECEIVE;
        end else begin
            st_d = ST_STANDBY;
        end
    end

    logic pll_on;
    assign pll_on = st_q != ST_SLEEP && cfg_q[A_AFE][AFE_LODIV_LSB +: 2] != 2'h0;

    always_comb begin
        lock_cnt_d = lock_cnt_q;
        locked_d = locked_q;
        if (!pll_on) begin
            lock_cnt_d = 16'h0000;
            locked_d = 1'b0;
        end else if (lock_cnt_q == 16'(LOCK_CYCLES - 1)) begin
            locked_d = 1'b1;
        end else begin
            lock_cnt_d = lock_cnt_q + 16'h0001;
        end
    end

    // Error word only moves while receiving, so a read after a packet holds
    assign fei_d = (st_q == ST_RECEIVE) ? fei_in : fei_q;

    ////////////////////////////////////////////////////////////////////
    // ASK decision and settling

    logic signed [7:0] avg_q, avg_d;
    logic data_q, data_d;
    logic [3:0] settle_q, settle_d;
    logic signed [7:0] lower_bound;
    logic signed [8:0] diff;
    logic signed [7:0] thr;
    logic entering;

    assign lower_bound = signed'(cfg_q[A_ASK_THRESHOLD_LOWER_BOUND]);
    assign diff = 9'(ask_sample) - 9'(avg_q);
    assign entering = st_d == ST_RECEIVE && st_q != ST_RECEIVE;

    always_comb begin
        // Method zero: running average floored at the bound; else bound only
        if (!cfg_q[A_THRESHOLD_METHOD][THRESHOLD_METHOD_BIT]) begin
            thr = (avg_q > lower_bound) ? avg_q : lower_bound;
        end else begin
            thr = lower_bound;
        end
    end

    always_comb begin
        avg_d = avg_q;
        settle_d = settle_q;
        if (entering) begin
            // Precharge with the bound so the filter starts near a level
            avg_d = lower_bound;
            settle_d = 4'h0;
        end else if (st_q == ST_RECEIVE) begin
            avg_d = avg_q + 8'(diff >>> ASK_AVG_SHIFT);
            if (bit_tick && settle_q != 4'(SETTLE_BITS)) begin
                settle_d = settle_q + 4'h1;
            end
        end
        data_d = (st_q == ST_RECEIVE) && (ask_sample > thr);
    end

    ////////////////////////////////////////////////////////////////////
    // LO and AFC arithmetic

    logic [23:0] lo_word;
    logic [AFC_W-1:0] afc_lim;
    logic [4:0] afc_exp;
    logic [23:0] lo_d;
    logic [15:0] afc_d;
    logic [39:0] lo_prod;
    logic [31:0] afc_prod;

    assign lo_word = {cfg_q[A_LO_HI], cfg_q[A_LO_MID], cfg_q[A_LO_LO]};
    assign afc_lim = cfg_q[A_AFC][AFC_LSB +: AFC_W];
    assign afc_exp = 5'(cfg_q[A_BW][BW_IF_BIT]) + 5'(cfg_q[A_BW][BW_CHF_LSB +: BW_CHF_W])
                   + 5'(AFC_EXP_BASE);
    assign lo_prod = 40'(lo_word) * 40'(XTAL_K);
    assign afc_prod = 32'(afc_lim) * 32'(XTAL_K);
    assign lo_d = 24'(lo_prod >> LO_FRAC_BITS);
    assign afc_d = 16'(afc_prod >> afc_exp);

    ////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int i = 0; i < REG_NUM; i++) begin
                cfg_q[i] <= reset_val(i);
            end
            ack_q <= 1'b0;
            rdata_q <= 8'h00;
            fei_q <= 8'sh00;
            locked_q <= 1'b0;
            lock_cnt_q <= 16'h0000;
            st_q <= ST_SLEEP;
            avg_q <= 8'sh00;
            data_q <= 1'b0;
            settle_q <= 4'h0;
            lo_freq_khz <= 24'h00_0000;
            afc_pull_khz <= 16'h0000;
        end else begin
            cfg_q <= cfg_d;
            ack_q <= ack_d;
            rdata_q <= rdata_d;
            fei_q <= fei_d;
            locked_q <= locked_d;
            lock_cnt_q <= lock_cnt_d;
            st_q <= st_d;
            avg_q <= avg_d;
            data_q <= data_d;
            settle_q <= settle_d;
            lo_freq_khz <= lo_d;
            afc_pull_khz <= afc_d;
        end
    end

    assign link.acc_ack = ack_q;
    assign link.acc_rdata = rdata_q;
    assign link.data_pin = data_q;
    assign ask_threshold = thr;
    assign data_valid = st_q == ST_RECEIVE && settle_q == 4'(SETTLE_BITS);
    assign rx_active = st_q == ST_RECEIVE;
endmodule
`default_nettype wire

// ===== rtl/rx_controller.sv
/*
 Controller end: power-up sequencing of the power-down pin and register
 accesses ordered by software over AXI4-Lite, with sticky interrupts.
 Assumes the device acknowledges each access while powered.
*/
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module rx_controller
    import rx_ctl_pkg::*;
#(
    parameter int PWR_HIGH_CYCLES = rx_ctl_pkg::PWR_HIGH_CYC,
    parameter int PWR_LOW_CYCLES = rx_ctl_pkg::PWR_LOW_CYC
) (
    input wire logic core_clk, // Clock
    input wire logic rst, // Synchronous reset, high
    rx_link_if.ctl link, // Device side
    input wire logic [7:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Byte enables
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [7:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    output logic irq // Interrupt, high while unmasked event pending
);
    import rx_ctl_pkg::*;

    host_state_t st_q, st_d;
    logic [15:0] cnt_q, cnt_d;
    logic pwr_q, pwr_d;
    logic we_q, we_d;
    logic [5:0] addr_q, addr_d;
    logic [7:0] wdata_q, wdata_d, res_q, res_d;
    logic [BANK_REGS-1:0] bank_q, bank_d;
    logic rx_on_q, rx_on_d;
    logic [EV_W-1:0] ist_q, ist_d, msk_q, msk_d, ev;
    logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
    logic [7:0] awa_q, awa_d;
    logic [31:0] wd_q, wd_d, rd_q, rd_d;
    logic [1:0] br_q, br_d, rr_q, rr_d;
    logic [3:0] ws_q, ws_d;
    logic commit, cmd_hit, refuse;
    logic [5:0] c_addr;

    // Bank slot of a device address, or none
    function automatic logic [BANK_REGS-1:0] bank_bit(input logic [5:0] a);
        bank_bit = '0;
        if (a <= A_BANK_LAST) begin
            bank_bit[a[3:0]] = 1'b1;
        end else if (a == A_AFE) begin
            bank_bit[BANK_REGS-1] = 1'b1;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave

    assign s_axi_awready = !aw_q && !bv_q;
    assign s_axi_wready = !w_q && !bv_q;
    assign s_axi_arready = !rv_q;
    assign commit = aw_q && w_q && !bv_q;
    assign cmd_hit = commit && awa_q == H_CMD && ws_q[0];
    assign c_addr = wd_q[CMD_ADDR_LSB +: ADDR_W];

    always_comb begin
        // Enable of reception waits for the full bank; the centre word
        // must not move while receiving
        refuse = 1'b0;
        if (wd_q[CMD_WE_BIT] && c_addr == A_STATE_CTRL && wd_q[STC_RX] && !(&bank_q)) begin
            refuse = 1'b1;
        end
        if (wd_q[CMD_WE_BIT] && rx_on_q && c_addr >= A_LO_HI && c_addr <= A_LO_LO) begin
            refuse = 1'b1;
        end
        if (st_q != H_READY) begin
            refuse = 1'b1;
        end
    end

    always_comb begin
        aw_d = aw_q;
        w_d = w_q;
        bv_d = bv_q;
        br_d = br_q;
        awa_d = awa_q;
        wd_d = wd_q;
        rv_d = rv_q;
        rd_d = rd_q;
        rr_d = rr_q;
        ws_d = ws_q;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_d = 1'b1;
            awa_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_d = 1'b1;
            wd_d = s_axi_wdata;
            ws_d = s_axi_wstrb;
        end
        if (commit) begin
            aw_d = 1'b0;
            w_d = 1'b0;
            bv_d = 1'b1;
            br_d = (awa_q == H_CMD || awa_q == H_IRQ_ST || awa_q == H_IRQ_MSK) ? RESP_OKAY : RESP_SLVERR;
        end else if (bv_q && s_axi_bready) begin
            bv_d = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rv_d = 1'b1;
            rr_d = RESP_OKAY;
            unique case (s_axi_araddr)
                H_CMD: rd_d = {15'h0000, we_q, 2'b00, addr_q, wdata_q};
                H_RESULT: rd_d = {22'h00_0000, st_q == H_READY, st_q == H_ACCESS, res_q};
                H_IRQ_ST: rd_d = 32'(ist_q);
                H_IRQ_MSK: rd_d = 32'(msk_q);
                H_PINS: rd_d = 32'(link.data_pin);
                default: begin
                    rd_d = 32'h0000_0000;
                    rr_d = RESP_SLVERR;
                end
            endcase
        end else if (rv_q && s_axi_rready) begin
            rv_d = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Power-up sequence and device accesses

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q + 16'h0001;
        pwr_d = pwr_q;
        we_d = we_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        res_d = res_q;
        bank_d = bank_q;
        rx_on_d = rx_on_q;
        ev = '0;
        unique case (st_q)
            H_PWR_HIGH: begin
                if (cnt_q == 16'(PWR_HIGH_CYCLES - 1)) begin
                    st_d = H_PWR_LOW;
                    pwr_d = 1'b0;
                    cnt_d = 16'h0000;
                end
            end
            H_PWR_LOW: begin
                if (cnt_q == 16'(PWR_LOW_CYCLES - 1)) begin
                    st_d = H_READY;
                    ev[EV_POWERED] = 1'b1;
                end
            end
            H_READY: begin
                cnt_d = cnt_q;
                if (cmd_hit && !refuse) begin
                    st_d = H_ACCESS;
                    we_d = wd_q[CMD_WE_BIT];
                    addr_d = c_addr;
                    wdata_d = wd_q[7:0];
                end
            end
            H_ACCESS: begin
                cnt_d = cnt_q;
                if (link.acc_ack) begin
                    st_d = H_READY;
                    res_d = link.acc_rdata;
                    ev[EV_DONE] = 1'b1;
                    if (we_q) begin
                        bank_d = bank_q | bank_bit(addr_q);
                        if (addr_q == A_STATE_CTRL) begin
                            rx_on_d = wdata_q[STC_RX] && wdata_q[STC_OSC];
                        end
                    end
                end
            end
        endcase
        if (cmd_hit && refuse) begin
            ev[EV_REFUSED] = 1'b1;
        end
    end

    always_comb begin
        msk_d = msk_q;
        ist_d = ist_q;
        if (commit && ws_q[0] && awa_q == H_IRQ_MSK) begin
            msk_d = wd_q[EV_W-1:0];
        end
        if (commit && ws_q[0] && awa_q == H_IRQ_ST) begin
            ist_d = ist_q & ~wd_q[EV_W-1:0];
        end
        // An event in the clearing cycle stays set
        ist_d = ist_d | ev;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_q <= H_PWR_HIGH;
            cnt_q <= 16'h0000;
            pwr_q <= 1'b1;
            we_q <= 1'b0;
            addr_q <= 6'h00;
            wdata_q <= 8'h00;
            res_q <= 8'h00;
            bank_q <= '0;
            rx_on_q <= 1'b0;
            ist_q <= '0;
            msk_q <= '0;
            aw_q <= 1'b0;
            w_q <= 1'b0;
            bv_q <= 1'b0;
            rv_q <= 1'b0;
            awa_q <= 8'h00;
            wd_q <= 32'h0000_0000;
            rd_q <= 32'h0000_0000;
            br_q <= RESP_OKAY;
            rr_q <= RESP_OKAY;
            ws_q <= 4'h0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            pwr_q <= pwr_d;
            we_q <= we_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            res_q <= res_d;
            bank_q <= bank_d;
            rx_on_q <= rx_on_d;
            ist_q <= ist_d;
            msk_q <= msk_d;
            aw_q <= aw_d;
            w_q <= w_d;
            bv_q <= bv_d;
            rv_q <= rv_d;
            awa_q <= awa_d;
            wd_q <= wd_d;
            rd_q <= rd_d;
            br_q <= br_d;
            rr_q <= rr_d;
            ws_q <= ws_d;
        end
    end

    assign link.power_down_pin = pwr_q;
    assign link.acc_req = st_q == H_ACCESS;
    assign link.acc_we = we_q;
    assign link.acc_addr = addr_q;
    assign link.acc_wdata = wdata_q;
    assign s_axi_bvalid = bv_q;
    assign s_axi_bresp = br_q;
    assign s_axi_rvalid = rv_q;
    assign s_axi_rdata = rd_q;
    assign s_axi_rresp = rr_q;
    assign irq = |(ist_q & msk_q);
endmodule
`default_nettype wire

// ===== verif/rx_link_asserts.sv
/* Link checker for the receiver link.
   Assumes the rx_link_if signals as plain inputs. */
`timescale 1ns/1ps
`default_nettype none
module rx_link_asserts (
    input wire logic core_clk, // Clock
    input wire logic rst, // Reset
    input wire logic power_down_pin, // Power-down
    input wire logic acc_req, // Request
    input wire logic acc_we, // Write
    input wire logic [5:0] acc_addr, // Address
    input wire logic [7:0] acc_wdata, // Write data
    input wire logic acc_ack, // Acknowledge
    input wire logic [7:0] acc_rdata, // Read data
    input wire logic data_pin // Data
);
    import rx_ctl_pkg::*;
    logic rx_en_q;
    logic rx_en_d;
    // Receive enable as last written, so centre word edits can be policed
    always_comb begin
        rx_en_d = rx_en_q;
        if (acc_ack && acc_we && acc_addr == A_STATE_CTRL) begin
            rx_en_d = acc_wdata[STC_RX];
        end
    end
    always_ff @(posedge core_clk) begin
        rx_en_q <= (rst || power_down_pin) ? 1'h0 : rx_en_d;
    end
    ////////////////////////////////////////
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    a_pwr_low_wait: assert property ($fell(power_down_pin) |-> !acc_req [*8])
        else $error("access too soon after power-up");
    a_no_ack_off: assert property (acc_ack |-> !$past(power_down_pin))
        else $error("ack while powered down");
    a_ack_bounded: assert property ($rose(acc_req) |-> ##[1:2] acc_ack)
        else $error("no ack for request");
    a_ack_caused: assert property (acc_ack |-> $past(acc_req) ##1 !acc_ack)
        else $error("stray or long ack");
    a_req_held: assert property (acc_req && !acc_ack |=> acc_req && $stable(acc_addr) && $stable(acc_wdata))
        else $error("request dropped early");
    a_lock_reserved: assert property (acc_ack && !acc_we && acc_addr == A_LOCK |-> !acc_rdata[1])
        else $error("reserved lock bit set");
    a_lo_locked_out: assert property (acc_req && acc_we && acc_addr inside {[A_LO_HI:A_LO_LO]} |-> !rx_en_q)
        else $error("centre word written in receive");
    a_data_quiet: assert property (power_down_pin |-> !data_pin)
        else $error("data while powered down");
endmodule
`default_nettype wire

// ===== verif/tb_receiver_state_and_afc_setup.sv
/* Bench: controller and device joined by rx_link_if, driven over AXI4-Lite.
   Assumes shortened power-up and lock counts. */
`timescale 1ns/1ps
`default_nettype none
module tb_receiver_state_and_afc_setup;
    import rx_ctl_pkg::*;
    localparam logic [31:0] LO_E = 32'((64'h001B_1B85 * XTAL_KHZ) >> LO_FRAC_BITS);
    localparam logic [31:0] AFC_E = 32'((7 * XTAL_KHZ) >> (3 + AFC_EXP_BASE));
    logic core_clk = 0;
    logic rst = 1;
    logic [7:0] awaddr = 0, araddr = 0;
    logic awvalid = 0, wvalid = 0, arvalid = 0, bready = 0, rready = 0;
    logic [31:0] wdata = 0, rdata, v;
    logic awready, wready, bvalid, arready, rvalid, irq, data_valid, rx_active;
    logic [1:0] bresp, rresp, resp, tick_q = 0;
    logic signed [7:0] ask_sample = 8'h80, fei_in = 8'hA3, ask_threshold;
    logic [23:0] lo_freq_khz;
    logic [15:0] afc_pull_khz;
    logic [7:0] bank [15] = '{8'h45, 8'h26, 8'h12, 8'h00, 8'h81, 8'h0D, 8'h0A, 8'h07, 8'h07, 8'h1B, 8'h1B,
        8'h85, 8'h0F, 8'h00, 8'h00};
    int err_total = 0, samples_checked = 0;
    always #50 core_clk = ~core_clk;
    always @(posedge core_clk) tick_q <= tick_q + 2'h1;
    rx_link_if rx_link_if_i (.core_clk(core_clk));
    rx_device #(.LOCK_CYCLES(5)) rx_device_i (.core_clk(core_clk), .rst(rst), .link(rx_link_if_i),
        .ask_sample(ask_sample), .bit_tick(tick_q == 2'h3), .fei_in(fei_in), .lo_freq_khz(lo_freq_khz),
        .afc_pull_khz(afc_pull_khz), .ask_threshold(ask_threshold), .data_valid(data_valid), .rx_active(rx_active));
    rx_controller #(.PWR_HIGH_CYCLES(20), .PWR_LOW_CYCLES(10)) rx_controller_i (.core_clk(core_clk), .rst(rst),
        .link(rx_link_if_i), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .irq(irq));
    rx_link_asserts rx_link_asserts_i (.core_clk(core_clk), .rst(rst), .power_down_pin(rx_link_if_i.power_down_pin),
        .acc_req(rx_link_if_i.acc_req), .acc_we(rx_link_if_i.acc_we), .acc_addr(rx_link_if_i.acc_addr),
        .acc_wdata(rx_link_if_i.acc_wdata), .acc_ack(rx_link_if_i.acc_ack), .acc_rdata(rx_link_if_i.acc_rdata),
        .data_pin(rx_link_if_i.data_pin));
    ////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        samples_checked++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        do begin
            @(posedge core_clk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
            bready <= !bvalid;
        end while (!bvalid);
        resp = bresp;
    endtask
    task automatic axr(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1;
        do begin
            @(posedge core_clk);
            if (arready) arvalid <= 0;
            rready <= !rvalid;
        end while (!rvalid);
        v = rdata;
        resp = rresp;
    endtask
    // Polls busy so each device access has finished before the next
    task automatic dev(input logic we, input logic [5:0] a, input logic [7:0] d);
        int n;
        axw(H_CMD, {15'h0, we, 2'h0, a, d});
        n = 0;
        do begin
            axr(H_RESULT);
            n++;
        end while (v[RES_BUSY_BIT] !== 1'h0 && n < 40);
        chk("idle", 0, v[RES_BUSY_BIT]);
    endtask
    task automatic dchk(input string n, input logic [5:0] a, input logic [7:0] e);
        dev(1'h0, a, 8'h01);
        chk(n, e, v[7:0]);
    endtask
    task automatic complete_run;
        $display("Checks made %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge core_clk);
        err_total++;
        complete_run;
    end
    initial begin
        repeat (8) @(posedge core_clk);
        rst <= 0;
        axw(H_IRQ_MSK, 32'h0000_0001);
        for (int i = 0; i < 60 && irq !== 1'h1; i++) @(posedge core_clk);
        chk("irq powered", 1, irq);
        axw(H_IRQ_ST, 32'h0000_0007);
        chk("irq cleared", 0, irq);
        axr(8'h40);
        chk("unmapped", RESP_SLVERR, resp);
        dev(1'h1, A_STATE_CTRL, 8'h04);
        dchk("standby", A_RX_STATE, RXS_STANDBY);
        dchk("ctrl bits", A_STATE_CTRL, 8'h04);
        dev(1'h1, A_STATE_CTRL, 8'h05);
        axr(H_IRQ_ST);
        chk("early rx", 1, v[EV_REFUSED]);
        for (int a = 0; a < 15; a++) dev(1'h1, a[5:0], bank[a]);
        dev(1'h1, A_AFE, 8'h95);
        chk("lo freq", LO_E, lo_freq_khz);
        chk("afc pull", AFC_E, afc_pull_khz);
        dev(1'h1, A_STATE_CTRL, 8'h05);
        chk("rx active", 1, rx_active);
        chk("settling", 0, data_valid);
        chk("threshold", 8'h81, {24'h0, ask_threshold});
        ask_sample <= 8'sh10;
        dchk("receive", A_RX_STATE, RXS_ACTIVE);
        dchk("lock", A_LOCK, 8'h01);
        dchk("fei", A_FEI, 8'hA3);
        axr(H_PINS);
        chk("data pin", 1, v[0]);
        repeat (60) @(posedge core_clk);
        chk("settled", 1, data_valid);
        axw(H_IRQ_ST, 32'h0000_0007);
        dev(1'h1, A_LO_HI, 8'h1B);
        axr(H_IRQ_ST);
        chk("lo locked", 1, v[EV_REFUSED]);
        dev(1'h1, A_STATE_CTRL, 8'h04);
        dchk("back standby", A_RX_STATE, RXS_STANDBY);
        dev(1'h1, A_LO_LO, 8'h2B);
        dchk("lo step", A_LO_LO, 8'h2B);
        dev(1'h1, A_ASK_THRESHOLD_LOWER_BOUND, 8'hAA);
        dev(1'h1, A_STATE_CTRL, 8'h00);
        chk("rx off", 0, rx_active);
        dchk("bound kept", A_ASK_THRESHOLD_LOWER_BOUND, 8'hAA);
        dchk("afe kept", A_AFE, 8'h95);
        complete_run;
    end
endmodule
`default_nettype wire
